// File: rtl/sesf_defines.vh
// constants for the sensor error status flag bank
`ifndef SESF_DEFINES_VH
`define SESF_DEFINES_VH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SESF_ADDR_STATUS       4'h0
`define SESF_ADDR_STATUS_CLR   4'h4
`define SESF_ADDR_CONTROL      4'h8
`define SESF_ADDR_FAULT_RAW    4'hC
// ----------------------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------------------
`define SESF_BIT_PARTICULATE   11
`define SESF_BIT_FORMALDEHYDE  10
`define SESF_BIT_CARBON_DIOXIDE 9
`define SESF_BIT_GAS            7
// ----------------------------------------------------------------------------
// control bit positions and reset values
// ----------------------------------------------------------------------------
`define SESF_CTRL_MEASURE      0
`define SESF_CTRL_SOFT_RESET   1
`define SESF_CONTROL_RESET     32'h0000_0000
`define SESF_FLAGS_RESET       4'h0
`define SESF_NUM_FLAGS         4
`endif

// File: rtl/sesf_flag.v
// one sticky sensing element error flag
`timescale 1ns/1ps
module sesf_flag (
  input  wire clk_sys,
  input  wire rst_b,
  input  wire measuring,
  input  wire fault,
  input  wire clear,
  output reg  flag
);
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (measuring && fault) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule // sesf_flag

// File: rtl/sesf_status_flags.v
// sticky sensing element error flags behind an Avalon-MM slave
`timescale 1ns/1ps
`include "sesf_defines.vh"
module sesf_status_flags (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [1:0]  avs_response,
  input  wire        particulate_fault,
  input  wire        formaldehyde_fault,
  input  wire        carbon_dioxide_fault,
  input  wire        gas_fault,
  output wire        measuring,
  output wire [31:0] status_word
);
  // --------------------------------------------------------------------------
  // bus handshake: one wait cycle, answer on the second edge
  // --------------------------------------------------------------------------
  reg        ack;
  wire       req      = (avs_read | avs_write) & ~ack;
  wire       rd_take  = avs_read & ack;
  wire       wr_take  = avs_write & ack;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= req;
    end
  end

  // --------------------------------------------------------------------------
  // response codes
  // --------------------------------------------------------------------------
  localparam [1:0] RESP_OKAY   = 2'b00;
  localparam [1:0] RESP_DECODE = 2'b11;

  // --------------------------------------------------------------------------
  // address decoding
  // --------------------------------------------------------------------------
  function is_status;
    input [3:0] a;
    begin
      is_status = (a == `SESF_ADDR_STATUS) || (a == `SESF_ADDR_STATUS_CLR);
    end
  endfunction

  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `SESF_ADDR_STATUS) || (a == `SESF_ADDR_STATUS_CLR) ||
               (a == `SESF_ADDR_CONTROL) || (a == `SESF_ADDR_FAULT_RAW);
    end
  endfunction

  // --------------------------------------------------------------------------
  // control register: measure mode and self-clearing soft reset
  // --------------------------------------------------------------------------
  reg  measure_mode;
  reg  soft_reset;
  wire ctrl_wr = wr_take && (avs_address == `SESF_ADDR_CONTROL) && avs_byteenable[0];
  assign measuring = measure_mode;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      measure_mode <= 1'b0;
      soft_reset   <= 1'b0;
    end else begin
      soft_reset <= ctrl_wr && avs_writedata[`SESF_CTRL_SOFT_RESET];
      if (soft_reset) begin
        measure_mode <= 1'b0;
      end else if (ctrl_wr) begin
        measure_mode <= avs_writedata[`SESF_CTRL_MEASURE];
      end
    end
  end

  // --------------------------------------------------------------------------
  // sticky flags
  // --------------------------------------------------------------------------
  // status bit of each flag slot; slot 3 is the particulate element
  function integer slot_bit;
    input integer slot;
    begin
      case (slot)
        3:       slot_bit = `SESF_BIT_PARTICULATE;
        2:       slot_bit = `SESF_BIT_FORMALDEHYDE;
        1:       slot_bit = `SESF_BIT_CARBON_DIOXIDE;
        default: slot_bit = `SESF_BIT_GAS;
      endcase
    end
  endfunction

  wire [3:0] faults;
  wire [3:0] flags;
  wire [3:0] reported;
  wire [3:0] flag_clear;
  wire       rc_take = rd_take && (avs_address == `SESF_ADDR_STATUS_CLR);

  assign faults = {particulate_fault, formaldehyde_fault,
                   carbon_dioxide_fault, gas_fault};

  genvar i;
  generate
    for (i = 0; i < `SESF_NUM_FLAGS; i = i + 1) begin : g_flag
      // snapshot bit the host is being handed in this read
      assign reported[i] = avs_readdata[slot_bit(i)];

      // a read-clear clears only flags already shown to the host (soft reset clears all); a flag raised
      // after the snapshot stays for the next read
      assign flag_clear[i] = (rc_take & reported[i]) | soft_reset;

      // set beats clear, so a fault in the clearing cycle survives
      sesf_flag u_flag (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .measuring (measure_mode),
        .fault     (faults[i]),
        .clear     (flag_clear[i]),
        .flag      (flags[i])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // status word
  // --------------------------------------------------------------------------
  reg [31:0] next_status;
  integer    k;

  always @* begin
    next_status = 32'h0000_0000;
    for (k = 0; k < `SESF_NUM_FLAGS; k = k + 1) begin
      next_status[slot_bit(k)] = flags[k];
    end
  end

  assign status_word = next_status;

  // --------------------------------------------------------------------------
  // bus response
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_response <= RESP_OKAY;
    end else if (req) begin
      if (mapped(avs_address)) begin
        avs_response <= RESP_OKAY;
      end else begin
        avs_response <= RESP_DECODE;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read data, taken before any clear lands
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req) begin
      if (is_status(avs_address)) begin
        avs_readdata <= next_status;
      end else begin
        case (avs_address)
          `SESF_ADDR_CONTROL:   avs_readdata <= {31'h0000_0000, measure_mode};
          `SESF_ADDR_FAULT_RAW: avs_readdata <= {28'h000_0000, faults};
          default:              avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // sesf_status_flags

// File: testbench/sesf_properties.sv
// assertions for the sensor error flag bank
`timescale 1ns/1ps
module sesf_properties (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        particulate_fault,
  input wire logic        formaldehyde_fault,
  input wire logic        carbon_dioxide_fault,
  input wire logic        gas_fault,
  input wire logic        measuring,
  input wire logic [31:0] status_word
);
  wire rc = avs_read && !avs_waitrequest && avs_address == 4'h4;
  wire sr = avs_write && !avs_waitrequest && avs_address == 4'h8 && avs_writedata[1];
  wire anyf = particulate_fault || formaldehyde_fault || carbon_dioxide_fault || gas_fault;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_part_set: assert property (measuring && particulate_fault |=> status_word[11])
    else $error("particulate flag not set");
  chk_form_set: assert property (measuring && formaldehyde_fault |=> status_word[10])
    else $error("formaldehyde flag not set");
  chk_co2_set: assert property (measuring && carbon_dioxide_fault |=> status_word[9])
    else $error("carbon dioxide flag not set");
  chk_gas_set: assert property (measuring && gas_fault |=> status_word[7])
    else $error("gas flag not set");
  chk_idle_no_set: assert property (!measuring |=> (status_word & ~$past(status_word)) == 0)
    else $error("flag set while idle");
  chk_flag_sticky: assert property (|($past(status_word) & ~status_word) |-> $past(rc) || $past(sr) || $past(sr, 2))
    else $error("flag dropped without clear");
  chk_rdclr_zero: assert property (rc && !(measuring && anyf) |=> (status_word & $past(avs_readdata)) == 0)
    else $error("read and clear left flags");
  chk_rdclr_keep: assert property (rc |=> ($past(status_word) & ~$past(avs_readdata) & ~status_word) == 0)
    else $error("unreported flag lost");
  chk_soft_clear: assert property (sr && !measuring |-> ##[1:2] (status_word == 0 && !measuring))
    else $error("soft reset left flags");
  chk_rdclr_old: assert property (rc |-> avs_readdata == $past(status_word))
    else $error("read and clear data wrong");
  cover property (rc && status_word != 0);
  cover property (sr);
  cover property (measuring && gas_fault);
endmodule // sesf_properties

// File: testbench/sesf_host.sv
// host controller model driving the register bus
`timescale 1ns/1ps
module sesf_host (
  input  wire logic        clk_sys,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [3:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
  task automatic access(input logic [3:0] a, input logic wr, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // sesf_host

// File: testbench/tb.sv
// self-checking bench for the sensor error flag bank
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb;
  logic        clk_sys = 0;
  logic        rst_b = 0;
  logic [3:0]  fault = 0;
  logic [3:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, measuring;
  logic [31:0] avs_writedata, avs_readdata, status_word, q;
  logic [1:0]  avs_response;
  int          fails = 0, total_checks = 0;
  logic [35:0] rows [4] = '{{4'h8, 32'h0000_0800}, {4'h4, 32'h0000_0400},
                            {4'h2, 32'h0000_0200}, {4'h1, 32'h0000_0080}};
  sesf_host host_i (.clk_sys, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
                    .avs_write, .avs_writedata);
  sesf_status_flags sesf_status_flags_i (.clk_sys, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .avs_response, .particulate_fault(fault[3]), .formaldehyde_fault(fault[2]),
    .carbon_dioxide_fault(fault[1]), .gas_fault(fault[0]), .measuring, .status_word);
  task print_verdict;
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #12.5 clk_sys = ~clk_sys;
  initial begin
    #100us;
    fails++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1;
    host_i.access(4'h8, 1, 32'h0000_0001, q);
    for (int i = 0; i < 4; i++) begin
      fault <= rows[i][35:32];
      host_i.access(4'h0, 0, 0, q);
      fault <= 4'h0;
      host_i.access(4'h0, 0, 0, q); `CHK(q, rows[i][31:0])
      host_i.access(4'h4, 0, 0, q); `CHK(q, rows[i][31:0])
      host_i.access(4'h0, 0, 0, q); `CHK(q, 32'h0000_0000)
    end
    fault <= 4'hF;
    host_i.access(4'h8, 1, 32'h0000_0000, q);
    host_i.access(4'h0, 0, 0, q); `CHK(q, 32'h0000_0E80)
    host_i.access(4'h8, 1, 32'h0000_0002, q);
    host_i.access(4'h0, 0, 0, q); `CHK(q, 32'h0000_0000)
    host_i.access(4'h8, 1, 32'h0000_0001, q);
    host_i.access(4'h0, 0, 0, q); `CHK(q, 32'h0000_0E80)
    `CHK(avs_response, 2'b00)
    host_i.access(4'h2, 0, 0, q); `CHK(q, 32'h0000_0000)
    `CHK(avs_response, 2'b11)
    host_i.access(4'hC, 0, 0, q); `CHK(q, 32'h0000_000F)
    host_i.access(4'h8, 0, 0, q); `CHK(q, 32'h0000_0001)
    host_i.access(4'h0, 0, 0, q); `CHK(q, 32'h0000_0E80)
    rst_b <= 0;
    @(posedge clk_sys);
    rst_b <= 1;
    host_i.access(4'h0, 0, 0, q); `CHK(q, 32'h0000_0000)
    print_verdict;
  end
endmodule // tb
bind sesf_status_flags sesf_properties sesf_properties_i (.clk_sys, .rst_b, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .particulate_fault,
  .formaldehyde_fault, .carbon_dioxide_fault, .gas_fault, .measuring, .status_word);
